//--- design/ftu_pkg.sv
/*
  Constants and types shared by the five-timer unit.
  Assumes a 100 MHz core clock.
*/
package ftu_pkg;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int unsigned F_CORE_KHZ = 100000;
  localparam int unsigned F_HF_KHZ   = 13560;
  localparam int unsigned ACC_W      = 17;
  localparam int unsigned LF_DIV     = 64;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(F_HF_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(F_CORE_KHZ - F_HF_KHZ);
  localparam logic [ACC_W-1:0] ACC_RST  = 17'h00000;
  localparam logic [5:0]       LF_LAST  = 6'(LF_DIV - 1);
  localparam logic [5:0]       LF_RST   = 6'h00;
  // ----------------------------------------
  // Clock select codes
  // ----------------------------------------
  localparam logic [1:0] SEL_HF   = 2'h0;
  localparam logic [1:0] SEL_LF   = 2'h1;
  localparam logic [1:0] SEL_WAKE = 2'h2;
  // ----------------------------------------
  // Register fields and reset values
  // ----------------------------------------
  localparam int unsigned GCTRL_NOW_LSB = 4;
  localparam int unsigned IRQ_SET_BIT   = 7;
  localparam int unsigned IRQ_WAKE_BIT  = 4;
  localparam int unsigned IRQ_ANY_BIT   = 6;
  localparam logic [7:0]  IRQ_RST       = 8'h00;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [1:0] {TMR_IDLE, TMR_ARMED, TMR_RUN} ftu_tmr_e;
  typedef enum logic [1:0] {PWR_ON, PWR_STBY, PWR_DET} ftu_pwr_e;
endpackage : ftu_pkg

//--- design/ftu_timer.sv
/*
  One down-counting timer channel with reload, start/stop events.
  Assumes tick and event inputs are single-cycle core-clock pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module ftu_timer #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_tick,
  input  wire logic             i_start,
  input  wire logic             i_stop,
  input  wire logic             i_wait_evt,
  input  wire logic             i_start_evt,
  input  wire logic             i_stop_evt,
  input  wire logic             i_stop_en,
  input  wire logic             i_autoreload,
  input  wire logic [CNT_W-1:0] i_reload,
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_running,
  output logic                  o_underflow
);
  if (CNT_W != 16) begin : g_bad_width
    $error("ftu_timer supports only a 16-bit counter");
  end

  typedef struct packed {
    ftu_pkg::ftu_tmr_e st;
    logic [CNT_W-1:0]  cnt;
    logic              run;
    logic              uf;
  } ftu_tmr_s;

  ftu_tmr_s q;
  ftu_tmr_s d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d    = q;
    d.uf = 1'b0;
    case (q.st)
      ftu_pkg::TMR_IDLE: begin
      end
      ftu_pkg::TMR_ARMED: begin
        if (i_start_evt) begin
          d.st = ftu_pkg::TMR_RUN;
        end
      end
      ftu_pkg::TMR_RUN: begin
        if (i_stop_en && i_stop_evt) begin
          d.st = ftu_pkg::TMR_IDLE;
        end else if (i_tick) begin
          if (q.cnt == '0) begin
            d.uf = 1'b1;
            if (i_autoreload) begin
              d.cnt = i_reload;
            end else begin
              d.st = ftu_pkg::TMR_IDLE;
            end
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
      end
      default: begin
        d.st = ftu_pkg::TMR_IDLE;
      end
    endcase
    if (i_stop) begin
      d.st = ftu_pkg::TMR_IDLE;
    end else if (i_start) begin
      d.cnt = i_reload;
      d.st  = i_wait_evt ? ftu_pkg::TMR_ARMED : ftu_pkg::TMR_RUN;
    end
    d.run = (d.st == ftu_pkg::TMR_RUN);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '{ftu_pkg::TMR_IDLE, '0, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_count     = q.cnt;
  assign o_running   = q.run;
  assign o_underflow = q.uf;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_tick_run;
    q.run && i_tick && q.cnt != '0 && !(i_stop_en && i_stop_evt)
      && !i_start && !i_stop;
  endsequence

  chk_start_load: assert property (i_start && !i_stop |=>
    q.cnt == $past(i_reload))
    else $error("counter not loaded at start");
  chk_count_down: assert property (s_tick_run |=>
    q.cnt == CNT_W'($past(q.cnt) - 1'b1))
    else $error("counter did not decrement");
  chk_uf_zero: assert property (q.uf |->
    $past(q.cnt) == '0 && $past(q.run) && $past(i_tick))
    else $error("underflow without zero count");
  chk_halt_zero: assert property (q.uf && !$past(i_autoreload)
    && !$past(i_start) |-> q.cnt == '0 && !q.run)
    else $error("one-shot timer did not halt at zero");
  chk_stop_hold: assert property (q.run && i_stop_en && i_stop_evt
    && !i_start |=> !q.run && !q.uf && q.cnt == $past(q.cnt))
    else $error("stop event did not freeze timer");
  chk_armed_wait: assert property (q.st == ftu_pkg::TMR_ARMED
    && !i_start_evt && !i_start |=> !q.run)
    else $error("armed timer ran without start event");
endmodule : ftu_timer
`default_nettype wire

//--- design/ftu_top.sv
/*
  Timer unit: four selectable-clock timers plus a wake-up timer,
  global run control, timer interrupt flags and standby wake-up.
  Assumes software control arrives as core-clock write strobes;
  the low-frequency oscillator arrives asynchronously on a pin.
*/
`timescale 1ns/100ps
`default_nettype none
module ftu_top #(
  parameter int unsigned N_TMR = 4
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_gctrl_wr,
  input  wire logic [7:0]      i_gctrl_wdata,
  output logic      [7:0]      o_timer_global_ctrl,
  input  wire logic [3:0]      i_mode_start,
  input  wire logic [3:0]      i_wait_evt,
  input  wire logic [3:0]      i_start_evt,
  input  wire logic [3:0]      i_stop_evt,
  input  wire logic [3:0]      i_stop_en,
  input  wire logic [3:0]      i_autoreload,
  input  wire logic [3:0][1:0] i_clk_sel,
  input  wire logic [3:0][7:0] i_reload_high,
  input  wire logic [3:0][7:0] i_reload_low,
  output logic      [3:0][7:0] o_count_high,
  output logic      [3:0][7:0] o_count_low,
  input  wire logic            i_low_freq_osc,
  input  wire logic            i_wake_start,
  input  wire logic            i_wake_stop,
  input  wire logic            i_wake_timer_autoreload,
  input  wire logic            i_auto_wake,
  input  wire logic [7:0]      i_wake_reload_high,
  input  wire logic [7:0]      i_wake_reload_low,
  output logic      [7:0]      o_wake_count_high,
  output logic      [7:0]      o_wake_count_low,
  output logic                 o_wake_running,
  input  wire logic            i_irq_status_1_wr,
  input  wire logic [7:0]      i_irq_status_1_wdata,
  input  wire logic            i_irq_status_1_en_wr,
  input  wire logic [7:0]      i_irq_status_1_en_wdata,
  input  wire logic            i_other_irq,
  input  wire logic            i_irq_pin_en,
  output logic      [7:0]      o_irq_status_1,
  output logic      [7:0]      o_irq_en_1,
  output logic                 o_irq,
  input  wire logic            i_standby_req,
  input  wire logic            i_detect_done,
  input  wire logic            i_card_detected,
  output logic                 o_standby,
  output logic                 o_detect
);
  if (N_TMR != 4) begin : g_bad_count
    $error("ftu_top supports exactly four general timers");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [ftu_pkg::ACC_W-1:0] acc;
    logic [5:0]                lfdiv;
    logic                      hf_tick;
    logic                      lf_tick;
    logic                      osc_s1;
    logic                      osc_s2;
    logic                      osc_p;
    logic                      lfo_tick;
    logic [7:0]                irq_status_1;
    logic [7:0]                en1;
    logic                      irq;
    ftu_pkg::ftu_pwr_e         pwr;
    logic                      stby;
    logic                      det;
  } ftu_top_s;

  ftu_top_s q;
  ftu_top_s d;

  logic [3:0]       tick;
  logic [3:0]       start;
  logic [3:0]       stop;
  logic [3:0]       running;
  logic [3:0]       uf;
  logic [3:0][15:0] count;
  logic [15:0]      wake_count;
  logic             wake_uf;
  logic             wake_run;
  logic [7:0]       ev;

  // ----------------------------------------
  // Per-timer clock select and commands
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_tmr
    always_comb begin
      case (i_clk_sel[g])
        ftu_pkg::SEL_HF:   tick[g] = q.hf_tick;
        ftu_pkg::SEL_LF:   tick[g] = q.lf_tick;
        ftu_pkg::SEL_WAKE: tick[g] = wake_uf;
        default:           tick[g] = 1'b0;
      endcase
    end

    assign start[g] = (i_gctrl_wr
                       && i_gctrl_wdata[ftu_pkg::GCTRL_NOW_LSB + g]
                       && i_gctrl_wdata[g])
                      || i_mode_start[g];
    assign stop[g]  = i_gctrl_wr
                      && i_gctrl_wdata[ftu_pkg::GCTRL_NOW_LSB + g]
                      && !i_gctrl_wdata[g];

    ftu_timer #(
      .CNT_W (16)
    ) u_tmr (
      .i_core_clk   (i_core_clk),
      .i_rst_n      (i_rst_n),
      .i_tick       (tick[g]),
      .i_start      (start[g]),
      .i_stop       (stop[g]),
      .i_wait_evt   (i_wait_evt[g]),
      .i_start_evt  (i_start_evt[g]),
      .i_stop_evt   (i_stop_evt[g]),
      .i_stop_en    (i_stop_en[g]),
      .i_autoreload (i_autoreload[g]),
      .i_reload     ({i_reload_high[g], i_reload_low[g]}),
      .o_count      (count[g]),
      .o_running    (running[g]),
      .o_underflow  (uf[g])
    );

    assign o_count_high[g] = count[g][15:8];
    assign o_count_low[g]  = count[g][7:0];
  end

  // ----------------------------------------
  // Wake-up timer
  // ----------------------------------------
  ftu_timer #(
    .CNT_W (16)
  ) u_wake (
    .i_core_clk   (i_core_clk),
    .i_rst_n      (i_rst_n),
    .i_tick       (q.lfo_tick),
    .i_start      (i_wake_start),
    .i_stop       (i_wake_stop),
    .i_wait_evt   (1'b0),
    .i_start_evt  (1'b0),
    .i_stop_evt   (1'b0),
    .i_stop_en    (1'b0),
    .i_autoreload (i_wake_timer_autoreload),
    .i_reload     ({i_wake_reload_high, i_wake_reload_low}),
    .o_count      (wake_count),
    .o_running    (wake_run),
    .o_underflow  (wake_uf)
  );

  assign ev = {3'h0, wake_uf, uf};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // Fractional divider for the 13.56 MHz tick
    d.hf_tick = 1'b0;
    d.lf_tick = 1'b0;
    if (q.acc >= ftu_pkg::ACC_WRAP) begin
      d.acc     = q.acc - ftu_pkg::ACC_WRAP;
      d.hf_tick = 1'b1;
      d.lfdiv   = q.lfdiv + 1'b1;
      d.lf_tick = (q.lfdiv == ftu_pkg::LF_LAST);
    end else begin
      d.acc = q.acc + ftu_pkg::ACC_STEP;
    end
    // Oscillator pin synchroniser and edge
    d.osc_s1   = i_low_freq_osc;
    d.osc_s2   = q.osc_s1;
    d.osc_p    = q.osc_s2;
    d.lfo_tick = q.osc_s2 && !q.osc_p;
    // Status 1: write set/clear, then events win
    if (i_irq_status_1_wr) begin
      if (i_irq_status_1_wdata[ftu_pkg::IRQ_SET_BIT]) begin
        d.irq_status_1[6:0] = q.irq_status_1[6:0] | i_irq_status_1_wdata[6:0];
      end else begin
        d.irq_status_1[6:0] = q.irq_status_1[6:0] & ~i_irq_status_1_wdata[6:0];
      end
    end
    d.irq_status_1 = d.irq_status_1 | ev;
    d.irq_status_1[ftu_pkg::IRQ_ANY_BIT] = i_other_irq;
    d.irq_status_1[ftu_pkg::IRQ_SET_BIT] = 1'b0;
    if (i_irq_status_1_en_wr) begin
      if (i_irq_status_1_en_wdata[ftu_pkg::IRQ_SET_BIT]) begin
        d.en1[6:0] = q.en1[6:0] | i_irq_status_1_en_wdata[6:0];
      end else begin
        d.en1[6:0] = q.en1[6:0] & ~i_irq_status_1_en_wdata[6:0];
      end
    end
    d.en1[ftu_pkg::IRQ_SET_BIT] = 1'b0;
    d.irq = i_irq_pin_en && |(q.irq_status_1 & q.en1);
    // Standby and card detection
    case (q.pwr)
      ftu_pkg::PWR_ON: begin
        if (i_standby_req) begin
          d.pwr = ftu_pkg::PWR_STBY;
        end
      end
      ftu_pkg::PWR_STBY: begin
        if (wake_uf) begin
          d.pwr = ftu_pkg::PWR_DET;
        end
      end
      ftu_pkg::PWR_DET: begin
        if (i_detect_done) begin
          if (!i_card_detected && i_auto_wake) begin
            d.pwr = ftu_pkg::PWR_STBY;
          end else begin
            d.pwr = ftu_pkg::PWR_ON;
          end
        end
      end
      default: begin
        d.pwr = ftu_pkg::PWR_ON;
      end
    endcase
    d.stby = (d.pwr == ftu_pkg::PWR_STBY);
    d.det  = (d.pwr == ftu_pkg::PWR_DET);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '{ftu_pkg::ACC_RST, ftu_pkg::LF_RST, 1'b0, 1'b0, 1'b0,
             1'b0, 1'b0, 1'b0, ftu_pkg::IRQ_RST, ftu_pkg::IRQ_RST,
             1'b0, ftu_pkg::PWR_ON, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_timer_global_ctrl = {4'h0, running};
  assign o_wake_count_high   = wake_count[15:8];
  assign o_wake_count_low    = wake_count[7:0];
  assign o_wake_running      = wake_run;
  assign o_irq_status_1      = q.irq_status_1;
  assign o_irq_en_1          = q.en1;
  assign o_irq               = q.irq;
  assign o_standby           = q.stby;
  assign o_detect            = q.det;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_gstart0;
    i_gctrl_wr && i_gctrl_wdata[ftu_pkg::GCTRL_NOW_LSB]
      && i_gctrl_wdata[0] && !i_wait_evt[0];
  endsequence

  sequence s_clear_write;
    i_irq_status_1_wr && !i_irq_status_1_wdata[ftu_pkg::IRQ_SET_BIT] && ev == 8'h00;
  endsequence

  chk_hf_spacing: assert property (q.hf_tick |=>
    !q.hf_tick [*6])
    else $error("13.56 MHz tick too frequent");
  chk_lf_align: assert property (q.lf_tick |-> q.hf_tick)
    else $error("212 kHz tick off the fast tick");
  chk_global_start: assert property (s_gstart0 |=> running[0])
    else $error("global start did not run timer 0");
  chk_flag_set: assert property (ev != 8'h00 |=>
    (q.irq_status_1 & $past(ev)) == $past(ev))
    else $error("underflow did not set its flag");
  chk_bit7_clear: assert property (s_clear_write |=>
    (q.irq_status_1[5:0] & $past(i_irq_status_1_wdata[5:0])) == 6'h00)
    else $error("clear write left a flag set");
  chk_bit7_set: assert property (i_irq_status_1_wr
    && i_irq_status_1_wdata[ftu_pkg::IRQ_SET_BIT] |=>
    (q.irq_status_1[5:0] & $past(i_irq_status_1_wdata[5:0]))
      == $past(i_irq_status_1_wdata[5:0]))
    else $error("set write did not set flags");
  chk_irq_pin: assert property (i_irq_pin_en
    && (q.irq_status_1 & q.en1) != 8'h00 |=> q.irq)
    else $error("interrupt pin not raised");
  chk_wake_exit: assert property (q.stby && wake_uf |=>
    !q.stby && q.det)
    else $error("wake underflow did not leave standby");
  chk_stay_awake: assert property (q.det && i_detect_done
    && !i_auto_wake |=> !q.stby && !q.det)
    else $error("returned to standby without auto wake");

  sequence s_stop0;
    i_gctrl_wr && i_gctrl_wdata[ftu_pkg::GCTRL_NOW_LSB]
      && !i_gctrl_wdata[0];
  endsequence

  sequence s_arm3;
    i_mode_start[3] && i_wait_evt[3] && !stop[3];
  endsequence

  sequence s_no_card;
    q.det && i_detect_done && i_auto_wake && !i_card_detected;
  endsequence

  chk_global_stop: assert property (s_stop0 |=> !running[0])
    else $error("global stop left timer 0 running");
  chk_mode_arm: assert property (s_arm3 |=> !running[3]
    && count[3] == $past({i_reload_high[3], i_reload_low[3]}))
    else $error("mode start did not arm timer 3");
  chk_any_flag: assert property (i_other_irq |=>
    q.irq_status_1[ftu_pkg::IRQ_ANY_BIT])
    else $error("global flag not raised");
  chk_pin_gated: assert property (!i_irq_pin_en |=> !q.irq)
    else $error("interrupt pin raised while gated");
  chk_stby_enter: assert property (q.pwr == ftu_pkg::PWR_ON
    && i_standby_req |=> q.stby)
    else $error("standby request ignored");
  chk_auto_sleep: assert property (s_no_card |=> q.stby)
    else $error("no card found but standby not re-entered");
endmodule : ftu_top
`default_nettype wire

//--- tb/test_five_timer_unit.sv
/*
  Self-checking bench for the five-timer unit top level.
  Assumes ftu_pkg and the design modules are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_five_timer_unit;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic            clk       = 1'b0;
  logic            rst_n     = 1'b0;
  logic            gc_wr     = 1'b0;
  logic [7:0]      gc_wd     = 8'h00;
  logic [3:0]      mode_st   = 4'h0;
  logic [3:0]      wait_evt  = 4'h0;
  logic [3:0]      start_evt = 4'h0;
  logic [3:0]      stop_evt  = 4'h0;
  logic [3:0]      stop_en   = 4'h0;
  logic [3:0]      arl       = 4'h0;
  logic [3:0][1:0] clk_sel   = '0;
  logic [3:0][7:0] rl_hi     = '0;
  logic [3:0][7:0] rl_lo     = '0;
  logic            low_freq_osc       = 1'b0;
  logic            wk_start  = 1'b0;
  logic            wk_stop   = 1'b0;
  logic            wk_arl    = 1'b0;
  logic            auto_wake = 1'b0;
  logic [7:0]      wk_rh     = 8'h00;
  logic [7:0]      wk_rl     = 8'h00;
  logic            ir_wr     = 1'b0;
  logic [7:0]      ir_wd     = 8'h00;
  logic            en_wr     = 1'b0;
  logic [7:0]      en_wd     = 8'h00;
  logic            other_irq = 1'b0;
  logic            pin_en    = 1'b0;
  logic            stby_req  = 1'b0;
  logic            det_done  = 1'b0;
  logic            card      = 1'b0;
  logic [7:0]      gctrl;
  logic [3:0][7:0] cnt_hi;
  logic [3:0][7:0] cnt_lo;
  logic            wk_run;
  logic [7:0]      wk_ch;
  logic [7:0]      wk_cl;
  logic [7:0]      irq_st;
  logic [7:0]      irq_en;
  logic            irq;
  logic            stby;
  logic            det;
  int              failures    = 0;
  int              comparisons = 0;
  int              seed;
  int              t;
  int              n;
  logic [15:0]     v;
  logic [15:0]     h;

  always #5 clk = ~clk;
  always #153 low_freq_osc = ~low_freq_osc;

  ftu_top #(.N_TMR(4)) dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_gctrl_wr(gc_wr),
    .i_gctrl_wdata(gc_wd), .o_timer_global_ctrl(gctrl),
    .i_mode_start(mode_st), .i_wait_evt(wait_evt),
    .i_start_evt(start_evt), .i_stop_evt(stop_evt), .i_stop_en(stop_en),
    .i_autoreload(arl), .i_clk_sel(clk_sel), .i_reload_high(rl_hi),
    .i_reload_low(rl_lo), .o_count_high(cnt_hi), .o_count_low(cnt_lo),
    .i_low_freq_osc(low_freq_osc), .i_wake_start(wk_start), .i_wake_stop(wk_stop),
    .i_wake_timer_autoreload(wk_arl), .i_auto_wake(auto_wake),
    .i_wake_reload_high(wk_rh), .i_wake_reload_low(wk_rl),
    .o_wake_count_high(wk_ch), .o_wake_count_low(wk_cl),
    .o_wake_running(wk_run),
    .i_irq_status_1_wr(ir_wr), .i_irq_status_1_wdata(ir_wd), .i_irq_status_1_en_wr(en_wr),
    .i_irq_status_1_en_wdata(en_wd), .i_other_irq(other_irq),
    .i_irq_pin_en(pin_en), .o_irq_status_1(irq_st), .o_irq_en_1(irq_en),
    .o_irq(irq), .i_standby_req(stby_req), .i_detect_done(det_done),
    .i_card_detected(card), .o_standby(stby), .o_detect(det)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] cnt(input int k);
    return {cnt_hi[k], cnt_lo[k]};
  endfunction : cnt

  function automatic int ticks(input int cyc);
    return cyc * int'(ftu_pkg::F_HF_KHZ) / int'(ftu_pkg::F_CORE_KHZ);
  endfunction : ticks

  function automatic logic [7:0] go(input int k, input logic run);
    logic [7:0] d;
    d = 8'h00;
    d[k] = run;
    d[k+4] = 1'b1;
    return d;
  endfunction : go

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi,
                         input string msg);
    comparisons++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk_rng

  task automatic wr(input int which, input logic [7:0] d);
    @(negedge clk);
    gc_wr = (which == 0);
    ir_wr = (which == 1);
    en_wr = (which == 2);
    gc_wd = d;
    ir_wd = d;
    en_wd = d;
    @(negedge clk);
    gc_wr = 1'b0;
    ir_wr = 1'b0;
    en_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic wait_run(input int k, input logic lvl, input int lim);
    for (n = 0; n < lim && gctrl[k] !== lvl; n++) @(negedge clk);
    chk(16'(gctrl[k]), 16'(lvl), "running wait");
  endtask : wait_run

  task automatic wait_det(input int lim);
    for (n = 0; n < lim && det !== 1'b1; n++) @(negedge clk);
    chk(16'(det), 16'h0001, "detect phase");
  endtask : wait_det

  task automatic set_rl(input int k, input logic [15:0] val);
    rl_hi[k] = val[15:8];
    rl_lo[k] = val[7:0];
  endtask : set_rl

  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, failures);
  endtask : done

  task automatic conclude();
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #200000;
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = 98;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(16'(gctrl), 16'h0000, "ctrl after reset");
    chk(16'(irq_st), 16'h0000, "status after reset");
    done("reset");
    for (t = 0; t < 4; t++) begin
      v = 16'h0100 | 16'($random(seed));
      clk_sel[t] = 2'h3; // No clock, so the load is seen untouched
      set_rl(t, v);
      wr(0, go(t, 1'b1));
      @(negedge clk);
      chk(16'(gctrl[t]), 16'h0001, "started");
      chk(cnt(t), v, "loaded");
      clk_sel[t] = ftu_pkg::SEL_HF;
      repeat (60) @(negedge clk);
      chk_rng(v - cnt(t), ticks(60) - 2, ticks(60) + 2, "hf");
      wr(0, go(t, 1'b0));
      @(negedge clk);
      h = cnt(t);
      chk(16'(gctrl[t]), 16'h0000, "stopped");
      repeat (30) @(negedge clk);
      chk(cnt(t), h, "held after stop");
    end
    done("start_stop");
    set_rl(0, 16'h0100);
    clk_sel[0] = ftu_pkg::SEL_LF;
    wr(0, go(0, 1'b1));
    repeat (1000) @(negedge clk);
    chk_rng(16'h0100 - cnt(0), ticks(1000) / int'(ftu_pkg::LF_DIV),
            ticks(1000) / int'(ftu_pkg::LF_DIV) + 1, "slow clock");
    wr(0, go(0, 1'b0));
    clk_sel[0] = ftu_pkg::SEL_HF;
    done("slow_clock");
    wr(2, 8'h8F);
    chk(16'(irq_en), 16'h000F, "enable set");
    pin_en = 1'b1;
    set_rl(0, 16'h0000);
    wr(0, go(0, 1'b1));
    wait_run(0, 1'b0, 100);
    repeat (3) @(negedge clk);
    chk(cnt(0), 16'h0000, "halt at zero");
    chk(16'(irq_st[0]), 16'h0001, "flag on underflow");
    chk(16'(irq), 16'h0001, "pin on underflow");
    wr(1, 8'h01);
    chk(16'(irq_st[0]), 16'h0000, "flag cleared");
    chk(16'(irq), 16'h0000, "pin released");
    wr(1, 8'h84);
    chk(16'(irq_st[3:0]), 16'h0004, "flag set by write");
    pin_en = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0000, "pin gated");
    wr(1, 8'h0F);
    done("underflow");
    arl[1] = 1'b1;
    set_rl(1, 16'h0002);
    wr(0, go(1, 1'b1));
    repeat (100) @(negedge clk);
    chk(16'(gctrl[1]), 16'h0001, "still running");
    chk_rng(cnt(1), 0, 2, "reloaded count");
    chk(16'(irq_st[1]), 16'h0001, "periodic flag");
    wr(1, 8'h02);
    repeat (40) @(negedge clk);
    chk(16'(irq_st[1]), 16'h0001, "flag again");
    wr(0, go(1, 1'b0));
    wr(1, 8'h0F);
    done("periodic");
    stop_en[2] = 1'b1;
    set_rl(2, 16'hFFFF);
    wr(0, go(2, 1'b1));
    repeat (50) @(negedge clk);
    stop_evt[2] = 1'b1;
    @(negedge clk);
    stop_evt[2] = 1'b0;
    repeat (2) @(negedge clk);
    h = cnt(2);
    chk(16'(gctrl[2]), 16'h0000, "stop event");
    repeat (100) @(negedge clk);
    chk(cnt(2), h, "count held");
    chk_rng(16'hFFFF - h, ticks(50) - 2, ticks(50) + 3, "elapsed");
    chk(16'(irq_st[2]), 16'h0000, "no flag");
    done("stop_watch");
    wait_evt[3] = 1'b1;
    set_rl(3, 16'h0200);
    @(negedge clk) mode_st[3] = 1'b1;
    @(negedge clk) mode_st[3] = 1'b0;
    repeat (40) @(negedge clk);
    chk(16'(gctrl[3]), 16'h0000, "armed waits");
    @(negedge clk) start_evt[3] = 1'b1;
    @(negedge clk) start_evt[3] = 1'b0;
    repeat (40) @(negedge clk);
    chk(16'(gctrl[3]), 16'h0001, "event start");
    chk_rng(16'h0200 - cnt(3), ticks(40) - 2, ticks(40) + 2, "armed");
    wr(0, go(3, 1'b0));
    done("armed");
    wk_rl = 8'h03;
    wk_arl = 1'b1;
    auto_wake = 1'b1;
    @(negedge clk) wk_start = 1'b1;
    @(negedge clk) wk_start = 1'b0;
    @(negedge clk);
    chk(16'(wk_run), 16'h0001, "wake running");
    chk_rng({wk_ch, wk_cl}, 2, 3, "wake loaded");
    clk_sel[0] = ftu_pkg::SEL_WAKE;
    set_rl(0, 16'h0002);
    wr(0, go(0, 1'b1));
    repeat (200) @(negedge clk);
    chk(16'(gctrl[0]), 16'h0001, "slow wake clock");
    wait_run(0, 1'b0, 1500);
    done("wake_clock");
    @(negedge clk);
    stby_req = 1'b1;
    wk_start = 1'b1; // Restart so the next wake is a full period away
    @(negedge clk);
    stby_req = 1'b0;
    wk_start = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(stby), 16'h0001, "in standby");
    wait_det(400);
    @(negedge clk) det_done = 1'b1;
    @(negedge clk) det_done = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(stby), 16'h0001, "back to standby");
    wait_det(400);
    auto_wake = 1'b0;
    @(negedge clk) det_done = 1'b1;
    @(negedge clk) det_done = 1'b0;
    repeat (2) @(negedge clk);
    chk({14'h0, stby, det}, 16'h0000, "stays powered");
    @(negedge clk) wk_stop = 1'b1;
    @(negedge clk) wk_stop = 1'b0;
    done("standby");
    other_irq = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'(irq_st[6]), 16'h0001, "global flag");
    other_irq = 1'b0;
    done("global");
    conclude();
  end
endmodule : test_five_timer_unit
`default_nettype wire
